/* bench/sdif_host.sv */
`timescale 1ns/10ps
// host serial master, link clock idle high between frames
module sdif_host
(
    output logic link_clock,
    output logic frame_n,
    output logic serial_data
);
    initial
    begin
        link_clock = 1'b1;
        frame_n = 1'b1;
        serial_data = 1'b1;
    end
    // one frame msb first, edges past sixteen carry filler
    task automatic send(input logic [15:0] w, input int edges, input int half);
        #3 frame_n = 1'b0;
        for (int i = 0; i < edges; i++)
        begin
            serial_data = (i < 16) ? w[15 - i] : ~serial_data;
            #(half) link_clock = 1'b0;
            #(half) link_clock = 1'b1;
        end
        #(half) frame_n = 1'b1;
        serial_data = ~serial_data; // no stale data
        #40;
    endtask
endmodule

/* bench/sdif_top_sva.sv */
`timescale 1ns/10ps
module sdif_top_sva
#(
    parameter int FIFO_DEPTH = 8
)
(
    input logic                 clock,
    input logic                 reset,
    input logic                 frame_n,
    input logic [11:0]          analog_output,
    input sdif_pkg::sdif_mode_t power_mode,
    input logic                 word_accepted,
    input logic                 frame_aborted
);
    logic [7:0] idle_r;
    logic [7:0] idle_nxt;
    default clocking @(posedge clock); endclocking
    // cycles since strobe last seen low
    always_comb
    begin
        idle_nxt = (idle_r == 8'hFF) ? idle_r : idle_r + 8'h01;
        if (!frame_n)
            idle_nxt = 8'h00;
    end
    // count register
    always_ff @(posedge clock)
    begin
        idle_r <= reset ? 8'hFF : idle_nxt;
    end
    AST_RST_CODE: assert property ($fell(reset) |-> analog_output == 12'h000)
        else $error("code not zero");
    AST_RST_MODE: assert property ($fell(reset) |-> power_mode == sdif_pkg::SDIF_PM_NORMAL)
        else $error("mode not normal");
    AST_CODE_HOLD: assert property (disable iff (reset) !word_accepted && !$past(reset) |-> $stable(analog_output))
        else $error("code moved");
    AST_MODE_HOLD: assert property (disable iff (reset) $changed(power_mode) |-> word_accepted || $past(reset))
        else $error("mode moved");
    AST_ACC_PULSE: assert property (disable iff (reset) word_accepted |=> !word_accepted)
        else $error("accept too long");
    AST_ABT_PULSE: assert property (disable iff (reset) frame_aborted |=> !frame_aborted)
        else $error("abort too long");
    AST_ACC_FRAME: assert property (disable iff (reset) word_accepted |-> idle_r <= 8'h0C)
        else $error("accept without frame");
    AST_ABT_RISE: assert property (disable iff (reset) frame_aborted |-> idle_r inside {[8'h01:8'h0C]})
        else $error("abort without rise");
endmodule
bind sdif_top sdif_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (.clock, .reset, .frame_n, .analog_output,
    .power_mode, .word_accepted, .frame_aborted);

/* bench/tb_serial_dac_input_frame.sv */
`timescale 1ns/10ps
module tb_serial_dac_input_frame;
    logic                 clock;
    logic                 reset = 1'b1;
    logic                 link_clock;
    logic                 frame_n;
    logic                 serial_data;
    logic [11:0]          analog_output;
    sdif_pkg::sdif_mode_t power_mode;
    logic                 word_accepted;
    logic                 frame_aborted;
    int                   error_cnt = 0;
    int                   num_checks = 0;

    sdif_top dut (.clock, .reset, .link_clock, .frame_n, .serial_data, .analog_output, .power_mode,
        .word_accepted, .frame_aborted);
    sdif_host u_host (.link_clock, .frame_n, .serial_data);
    // system clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // verdict
    task automatic test_done;
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // frame, bounded wait for status pulse, then held outputs
    task automatic frame(input logic [15:0] w, input int edges, input int half, input logic [13:0] exp);
        logic hit;
        hit = 1'b0;
        fork
            u_host.send(w, edges, half);
            for (int n = 0; n < 120 && hit !== 1'b1; n++)
            begin
                @(posedge clock);
                #1 hit = (edges < 16) ? frame_aborted : word_accepted;
            end
        join
        check("pulse", {15'h0, hit}, 16'h0001);
        check("output", {2'h0, power_mode, analog_output}, {2'h0, exp});
        if (hit !== 1'b1)
            test_done;
    endtask
    // reset six cycles, zero code after
    task automatic do_reset;
        @(posedge clock);
        reset <= 1'b1;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1 check("reset", {2'h0, power_mode, analog_output}, 16'h0000);
    endtask
    // every mode, codes 801 and FFF, fast and slow link
    task automatic t_modes;
        logic [11:0] c;
        for (int m = 0; m < 4; m++)
        begin
            c = m[0] ? 12'hFFF : 12'h801;
            frame({2'h3, m[1:0], c}, 16, 6 + 14 * m[1], {m[1:0], c});
        end
    endtask
    // short frame dropped, long frame keeps first sixteen bits
    task automatic t_abort;
        frame(16'h0123, 15, 6, 14'h3FFF);
        frame(16'h1A5C, 20, 6, 14'h1A5C);
    endtask
    // main sequence
    initial
    begin
        do_reset;
        t_modes;
        t_abort;
        do_reset;
        test_done;
    end
endmodule

/* src/sdif_pkg.sv */
// What this block does
// - The low frame strobe is a level that enables the shift register and opens a new frame.
// - In a frame each falling serial clock edge shifts the data bit into a sixteen-bit register.
// - After the sixteenth falling edge the shifted word is transferred and the converter value updated.
// - A strobe rising before the sixteenth edge aborts the frame, dropping the partial word, value and mode kept.
// - Reset drives the zero output code, held until the first complete valid write.
// - Three power-down modes besides normal operation are chosen only by a serial write.
// - One twelve-bit converter value, taken from the accepted word, sets the output level.
package sdif_pkg;
    localparam int WORD_BITS    = 16;
    localparam int CODE_BITS    = 12;
    localparam int MODE_LSB     = 12;
    localparam int CNT_BITS     = 5;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam int FIFO_DEPTH   = 8;
    localparam int LINK_MAX_MHZ = 30;

    // power mode field, two bits above the code
    typedef enum logic [1:0] {
        SDIF_PM_NORMAL = 2'b00,
        SDIF_PM_PD_1K  = 2'b01,
        SDIF_PM_PD_100K = 2'b10,
        SDIF_PM_PD_HIZ = 2'b11
    } sdif_mode_t;

    typedef struct packed {
        sdif_mode_t  mode;
        logic [11:0] code;
    } sdif_word_t;
endpackage

/* src/sdif_top.sv */
`timescale 1ns/10ps
// serial input frame front end of a 12-bit converter
module sdif_fifo
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      wp_nxt;
    logic [AW:0]      rp_r;
    logic [AW:0]      rp_nxt;
    logic             push;
    logic             pop;

    // pointer arithmetic
    always_comb
    begin
        in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
        out_valid = wp_r != rp_r;
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wp_nxt    = push ? wp_r + 1'b1 : wp_r;
        rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
        out_data  = mem_r[rp_r[AW-1:0]];
    end

    // storage and pointers
    always_ff @(posedge clock)
    begin
        if (push)
            mem_r[wp_r[AW-1:0]] <= in_data;
        if (reset)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
endmodule

module sdif_top
#(
    parameter int FIFO_DEPTH = sdif_pkg::FIFO_DEPTH
)
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        link_clock,
    input  wire logic        frame_n,
    input  wire logic        serial_data,
    output logic [11:0]      analog_output,
    output sdif_pkg::sdif_mode_t power_mode,
    output logic             word_accepted,
    output logic             frame_aborted
);
    localparam int WB = sdif_pkg::WORD_BITS;
    localparam int CB = sdif_pkg::CNT_BITS;

    // ---------- link domain (falling edges of link_clock) ----------
    logic [WB-1:0] shift_r;
    logic [WB-1:0] shift_nxt;
    logic [CB-1:0] cnt_r;
    logic [CB-1:0] cnt_nxt;
    logic [WB-1:0] hold_r;
    logic [WB-1:0] hold_nxt;
    logic          tgl_r = 1'b0;                             // link side has no reset; known start level
    logic          tgl_nxt;

    // shift while strobe low, count edges, capture on the sixteenth
    always_comb
    begin
        shift_nxt = {shift_r[WB-2:0], serial_data};
        cnt_nxt   = cnt_r;
        hold_nxt  = hold_r;
        tgl_nxt   = tgl_r;
        if (cnt_r < CB'(WB))
            cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CB'(WB - 1))
        begin
            hold_nxt = shift_nxt;
            tgl_nxt  = ~tgl_r;
        end
    end

    // strobe high clears the frame asynchronously: a high strobe is the frame's own end
    always_ff @(negedge link_clock or posedge frame_n)
    begin
        if (frame_n)
        begin
            cnt_r   <= '0;
            shift_r <= '0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
        end
    end

    // completed word and event toggle, only touched by a full frame
    always_ff @(negedge link_clock)
    begin
        hold_r <= hold_nxt;
        tgl_r  <= tgl_nxt;
    end

    // ---------- system domain ----------
    logic              tgl_s1_r;
    logic              tgl_s2_r;
    logic              tgl_s3_r;
    logic              fr_s1_r;
    logic              fr_s2_r;
    logic              fr_s3_r;
    logic              tgl_init_r;
    logic              new_word;
    sdif_pkg::sdif_word_t word_in;
    sdif_pkg::sdif_word_t fifo_word;
    logic              fifo_in_ready;
    logic              fifo_valid;
    logic [11:0]       code_r;
    logic [11:0]       code_nxt;
    sdif_pkg::sdif_mode_t mode_r;
    sdif_pkg::sdif_mode_t mode_nxt;
    logic              acc_r;
    logic              acc_nxt;
    logic              abt_r;
    logic              abt_nxt;
    logic              pend_r;
    logic              pend_nxt;

    // toggle and strobe synchronisers
    always_ff @(posedge clock)
    begin
        tgl_s1_r <= tgl_r;
        tgl_s2_r <= tgl_s1_r;
        fr_s1_r  <= frame_n;
        fr_s2_r  <= fr_s1_r;
        if (reset)
        begin
            tgl_s3_r   <= 1'b0;
            fr_s3_r    <= 1'b1;
            tgl_init_r <= 1'b1;
        end
        else
        begin
            tgl_s3_r   <= tgl_init_r ? tgl_s2_r : tgl_s3_r ^ new_word;
            fr_s3_r    <= fr_s2_r;
            tgl_init_r <= 1'b0;
        end
    end

    // event from link; held word is stable for many cycles after the toggle
    always_comb
    begin
        new_word = !tgl_init_r && (tgl_s2_r != tgl_s3_r) && fifo_in_ready;
        word_in  = sdif_pkg::sdif_word_t'(hold_r[13:0]);
    end

    sdif_fifo #(
        .WIDTH ($bits(sdif_pkg::sdif_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (new_word),
        .in_ready  (fifo_in_ready),
        .in_data   (word_in),
        .out_valid (fifo_valid),
        .out_ready (1'b1),
        .out_data  (fifo_word)
    );

    // apply accepted words; flag frames that ended short
    always_comb
    begin
        code_nxt = code_r;
        mode_nxt = mode_r;
        acc_nxt  = 1'b0;
        abt_nxt  = 1'b0;
        pend_nxt = pend_r;
        if (fifo_valid)
        begin
            code_nxt = fifo_word.code;
            mode_nxt = fifo_word.mode;
            acc_nxt  = 1'b1;
        end
        if (!fr_s2_r && fr_s3_r)
            pend_nxt = 1'b1;
        if (new_word)
            pend_nxt = 1'b0;
        if (fr_s2_r && !fr_s3_r)
        begin
            abt_nxt  = pend_r && !new_word;
            pend_nxt = 1'b0;
        end
    end

    // output state, zero code after reset
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            code_r <= sdif_pkg::CODE_RESET;
            mode_r <= sdif_pkg::SDIF_PM_NORMAL;
            acc_r  <= 1'b0;
            abt_r  <= 1'b0;
            pend_r <= 1'b0;
        end
        else
        begin
            code_r <= code_nxt;
            mode_r <= mode_nxt;
            acc_r  <= acc_nxt;
            abt_r  <= abt_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign analog_output = code_r;
    assign power_mode    = mode_r;
    assign word_accepted = acc_r;
    assign frame_aborted = abt_r;
endmodule
